// ===== temperature_fault_response.v
// temperature fault response: response bytes, output disable, retry, sticky status
`timescale 1ns/1ps
`include "temp_fault_map.vh"

// How it works
// - internal response codes 00 and 01 are refused with a CML fault.
// - internal code 10 disables output at once, then follows the retry field.
// - internal code 11 disables output only while the fault stays present.
// - internal retry 000 keeps output off until the fault flag clears.
// - internal retry codes 001 to 111 are refused with a CML fault.
// - the delay field bits 2:0 is ignored by all fault logic.
// - any temperature fault sets its status bit and raises alert unless masked.
// - fault bits stay set until clear faults, an off edge of the run command, or reset.
// - internal overtemperature sets vendor summary bit and vendor overtemp bit.
// - internal response byte is read-only, unpaged, default C0.
// - external overtemp byte at 50, per page, read/write, default B8.
// - external undertemp byte at 54, per page, read/write, default B8.
// - external overtemp sets temperature summary bit and overtemp status bit.
// - external faults may take up to 120 ms to act on.
// - external codes: 00 continue, 10 shut down with retry, 01/11 refused.
// - external retry 111 restarts at each retry tick until commanded off.
// - external undertemp sets undertemp status bit, summary bit, and alert.
module temperature_fault_response (
  input wire clk_sys_i, // 20 MHz system clock
  input wire srst_i, // synchronous reset, active high
  input wire wr_stb_i, // one-cycle write strobe from command decoder
  input wire [7:0] wr_cmd_i, // command code of the write
  input wire [7:0] wr_data_i, // data byte of the write
  input wire page_i, // selected page (channel)
  input wire [7:0] rd_cmd_i, // command code being read
  output reg [7:0] rd_data_o, // read data for rd_cmd_i on page_i
  input wire clear_faults_i, // one-cycle clear faults command
  input wire [1:0] run_cmd_i, // per channel on command (pin and operation)
  input wire int_ot_i, // internal overtemperature condition (pin domain)
  input wire [1:0] ext_ot_i, // external overtemp per channel, from adc
  input wire [1:0] ext_ut_i, // external undertemp per channel, from adc
  input wire retry_tick_i, // one-cycle pulse at restart interval
  input wire [1:0] alert_mask_i, // bit0 masks internal ot, bit1 masks external
  output reg [1:0] out_en_o, // per channel output enable
  output reg cml_fault_o, // pulse: refused write
  output reg alert_o, // alert request, active high level
  output reg vendor_summary_bit_o, // status word vendor summary bit
  output reg int_ot_flag_o, // vendor status overtemp fault bit
  output reg [1:0] temp_summary_o, // status byte temperature bit per channel
  output reg [1:0] ext_ot_flag_o, // status temperature overtemp bit per channel
  output reg [1:0] ext_ut_flag_o // status temperature undertemp bit per channel
);

  // adc paced detection: worst-case response figure, cycles derived from rate
  // kept as a bound only: the pacing lives in the adc, so no timer is built here
  localparam integer ADC_RESP_CYC = (`ADC_RESPONSE_MS * (`CLK_HZ / 1000));

  reg [7:0] ext_ot_act_q [0:`NCHAN-1];
  reg [7:0] ext_ut_act_q [0:`NCHAN-1];
  reg int_ot_s1_q, int_ot_q;
  reg [1:0] run_q;
  reg [1:0] ot_in_q, ut_in_q;
  reg [1:0] latched_off_q; // channel held off by a shutdown response
  reg [1:0] no_retry_q; // latch came from a source that forbids restart
  wire [7:0] int_act = `RST_INT_ACTION; // fixed, unpaged, read-only

  // response byte legality checks; external reads only bits 7:6, internal reads bit 7 and retry bits 5:3
  function ext_ok;
    input [7:0] b;
    begin
      ext_ok = (b[`RESP_HI:`RESP_LO] == `RESP_CONTINUE) ||
               (b[`RESP_HI:`RESP_LO] == `RESP_SHUTDOWN);
    end
  endfunction

  function int_ok;
    input [7:0] b;
    begin
      int_ok = b[`RESP_HI] && (b[`RETRY_HI:`RETRY_LO] == `RETRY_NONE);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // two-flop synchroniser on the internal overtemp comparator
  // only the second flop is read; the adc levels and run command share this
  // clock and take one stage for timing, not for metastability
  always @(posedge clk_sys_i) begin
    if (srst_i) begin
      int_ot_s1_q <= 1'b0;
      int_ot_q <= 1'b0;
      ot_in_q <= 2'b00;
      ut_in_q <= 2'b00;
      run_q <= 2'b00;
    end else begin
      int_ot_s1_q <= int_ot_i;
      int_ot_q <= int_ot_s1_q;
      ot_in_q <= ext_ot_i;
      ut_in_q <= ext_ut_i;
      run_q <= run_cmd_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // write path and cml fault; a refused byte is not stored
  // unknown command codes are ignored here, they belong to other decoders
  always @(posedge clk_sys_i) begin
    if (srst_i) begin
      cml_fault_o <= 1'b0;
    end else begin
      cml_fault_o <= 1'b0;
      if (wr_stb_i) begin
        case (wr_cmd_i)
          `CMD_EXT_OT_ACTION, `CMD_EXT_UT_ACTION: cml_fault_o <= ~ext_ok(wr_data_i);
          `CMD_INT_OT_ACTION: cml_fault_o <= ~int_ok(wr_data_i);
          default: cml_fault_o <= 1'b0;
        endcase
      end
    end
  end

  genvar c;
  generate
    for (c = 0; c < `NCHAN; c = c + 1) begin : g_chan
      wire wr_here = wr_stb_i && (page_i == c) && ext_ok(wr_data_i);
      wire off_edge = run_q[c] && !run_cmd_i[c];
      wire [1:0] ot_resp = ext_ot_act_q[c][`RESP_HI:`RESP_LO];
      wire [1:0] ut_resp = ext_ut_act_q[c][`RESP_HI:`RESP_LO];
      wire [2:0] ot_rty = ext_ot_act_q[c][`RETRY_HI:`RETRY_LO];
      wire [2:0] ut_rty = ext_ut_act_q[c][`RETRY_HI:`RETRY_LO];
      wire ot_trip = ot_in_q[c] && (ot_resp == `RESP_SHUTDOWN);
      wire ut_trip = ut_in_q[c] && (ut_resp == `RESP_SHUTDOWN);
      wire int_trip = int_ot_q && (int_act[`RESP_HI:`RESP_LO] == `RESP_SHUTDOWN);
      wire int_hold = int_ot_q && (int_act[`RESP_HI:`RESP_LO] == `RESP_WHILE_PRESENT);
      // a trip whose own retry field is not 111 pins the latch until clear or off;
      // checking only the sources present at the tick would let a fault that has
      // gone away restart the output although its retry field said no restart
      wire trip_pins = (ot_trip && (ot_rty != `RETRY_FOREVER)) ||
                       (ut_trip && (ut_rty != `RETRY_FOREVER)) || int_trip;
      // restart needs an unpinned latch and no internal flag standing against it
      wire may_retry = !no_retry_q[c] && !trip_pins && !int_ot_flag_o;

      // paged response storage, defaults on reset
      always @(posedge clk_sys_i) begin
        if (srst_i) begin
          ext_ot_act_q[c] <= `RST_EXT_ACTION;
          ext_ut_act_q[c] <= `RST_EXT_ACTION;
        end else if (wr_here && wr_cmd_i == `CMD_EXT_OT_ACTION) begin
          ext_ot_act_q[c] <= wr_data_i;
        end else if (wr_here && wr_cmd_i == `CMD_EXT_UT_ACTION) begin
          ext_ut_act_q[c] <= wr_data_i;
        end
      end

      // sticky flags: set wins over clear; off command also clears
      always @(posedge clk_sys_i) begin
        if (srst_i) begin
          ext_ot_flag_o[c] <= 1'b0;
          ext_ut_flag_o[c] <= 1'b0;
          temp_summary_o[c] <= 1'b0;
        end else begin
          ext_ot_flag_o[c] <= ot_in_q[c] ||
            (ext_ot_flag_o[c] && !clear_faults_i && !off_edge);
          ext_ut_flag_o[c] <= ut_in_q[c] ||
            (ext_ut_flag_o[c] && !clear_faults_i && !off_edge);
          temp_summary_o[c] <= ot_in_q[c] || ut_in_q[c] ||
            (temp_summary_o[c] && !clear_faults_i && !off_edge);
        end
      end

      // pin flag: remembers that the present latch may not be lifted by a tick;
      // set wins over clear so a trip in the clear cycle keeps the output off
      always @(posedge clk_sys_i) begin
        if (srst_i) begin
          no_retry_q[c] <= 1'b0;
        end else if (trip_pins) begin
          no_retry_q[c] <= 1'b1;
        end else if (clear_faults_i || off_edge) begin
          no_retry_q[c] <= 1'b0;
        end
      end

      // shutdown latch with retry; code 11 gates output only while present
      always @(posedge clk_sys_i) begin
        if (srst_i) begin
          latched_off_q[c] <= 1'b0;
          out_en_o[c] <= 1'b0;
        end else begin
          if (ot_trip || ut_trip || int_trip)
            latched_off_q[c] <= 1'b1;
          else if (clear_faults_i || off_edge)
            latched_off_q[c] <= 1'b0;
          else if (retry_tick_i && may_retry)
            latched_off_q[c] <= 1'b0;
          out_en_o[c] <= run_cmd_i[c] && !latched_off_q[c] && !ot_trip && !ut_trip &&
                         !int_trip && !int_hold;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // internal overtemp status, alert and read mux
  // alert follows the registered flags, so it trails a new flag by one cycle;
  // read data is registered too, a changed select shows one cycle later
  always @(posedge clk_sys_i) begin
    if (srst_i) begin
      int_ot_flag_o <= 1'b0;
      vendor_summary_bit_o <= 1'b0;
      alert_o <= 1'b0;
      rd_data_o <= 8'h00;
    end else begin
      int_ot_flag_o <= int_ot_q ||
        (int_ot_flag_o && !clear_faults_i && !(|(run_q & ~run_cmd_i)));
      vendor_summary_bit_o <= int_ot_q ||
        (vendor_summary_bit_o && !clear_faults_i && !(|(run_q & ~run_cmd_i)));
      alert_o <= (int_ot_flag_o && !alert_mask_i[0]) ||
                 ((|temp_summary_o) && !alert_mask_i[1]);
      case (rd_cmd_i)
        `CMD_EXT_OT_ACTION: rd_data_o <= ext_ot_act_q[page_i];
        `CMD_EXT_UT_ACTION: rd_data_o <= ext_ut_act_q[page_i];
        `CMD_INT_OT_ACTION: rd_data_o <= int_act;
        default: rd_data_o <= 8'h00;
      endcase
    end
  end

endmodule // temperature_fault_response

// ===== temp_fault_map.vh
// command codes, field positions, reset values and timing for the temperature fault block
`ifndef TEMP_FAULT_MAP_VH
`define TEMP_FAULT_MAP_VH
`define CMD_EXT_OT_ACTION 8'h50
`define CMD_EXT_UT_ACTION 8'h54
`define CMD_INT_OT_ACTION 8'hD0
`define RST_EXT_ACTION 8'hB8
`define RST_INT_ACTION 8'hC0
`define RESP_HI 7
`define RESP_LO 6
`define RETRY_HI 5
`define RETRY_LO 3
`define RESP_CONTINUE 2'b00
`define RESP_UNSUP 2'b01
`define RESP_SHUTDOWN 2'b10
`define RESP_WHILE_PRESENT 2'b11
`define RETRY_NONE 3'b000
`define RETRY_FOREVER 3'b111
`define ADC_RESPONSE_MS 120
`define CLK_HZ 20000000
`define NCHAN 2
`endif

// ===== temperature_fault_response_asserts.sv
// concurrent checks on the temperature fault block ports
`timescale 1ns/1ps
`include "temp_fault_map.vh"
module temperature_fault_response_asserts (
  input wire clk_sys_i, srst_i, wr_stb_i, int_ot_i, clear_faults_i, // controls
  input wire [7:0] wr_cmd_i, wr_data_i, // write bus
  input wire [1:0] run_cmd_i, ext_ot_i, alert_mask_i, out_en_o, ext_ot_flag_o, // channel pairs
  input wire cml_fault_o, alert_o, vendor_summary_bit_o, int_ot_flag_o // status outputs
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);
  //////////////////////////////////////////////////////////////////////
  // refused writes pulse cml one cycle after the strobe, never otherwise
  a_cml_ext_code: assert property (wr_stb_i && (wr_cmd_i == `CMD_EXT_OT_ACTION ||
    wr_cmd_i == `CMD_EXT_UT_ACTION) && wr_data_i[6] |=> cml_fault_o) else $error("ext cml");
  a_cml_int_code: assert property (wr_stb_i && wr_cmd_i == `CMD_INT_OT_ACTION &&
    (!wr_data_i[7] || wr_data_i[5:3] != 3'b000) |=> cml_fault_o) else $error("int cml");
  a_cml_idle: assert property (!wr_stb_i |=> !cml_fault_o) else $error("stray cml");
  // adc level is registered once, flag lands two edges later
  a_ext_flag_set: assert property (ext_ot_i[0] |-> ##2 ext_ot_flag_o[0])
    else $error("ext flag late");
  // two sync flops put the internal flag one edge behind the external one
  a_int_flag_set: assert property (int_ot_i |-> ##3 int_ot_flag_o && vendor_summary_bit_o)
    else $error("int flag late");
  a_int_hold_off: assert property (int_ot_i [*5] |-> out_en_o == 2'b00)
    else $error("output on in fault");
  // flag may only drop on clear faults or an off edge of the run command
  a_flag_sticky: assert property (ext_ot_flag_o[0] && !clear_faults_i && run_cmd_i[0] &&
    $past(run_cmd_i[0]) |=> ext_ot_flag_o[0]) else $error("flag dropped");
  a_alert_raise: assert property (ext_ot_flag_o[0] && !alert_mask_i[1] && !clear_faults_i &&
    run_cmd_i[0] |=> alert_o) else $error("no alert");
endmodule // temperature_fault_response_asserts
bind temperature_fault_response temperature_fault_response_asserts chk_inst (
  .clk_sys_i(clk_sys_i), .srst_i(srst_i), .wr_stb_i(wr_stb_i), .int_ot_i(int_ot_i),
  .clear_faults_i(clear_faults_i), .wr_cmd_i(wr_cmd_i), .wr_data_i(wr_data_i),
  .run_cmd_i(run_cmd_i), .ext_ot_i(ext_ot_i), .alert_mask_i(alert_mask_i),
  .out_en_o(out_en_o), .ext_ot_flag_o(ext_ot_flag_o), .cml_fault_o(cml_fault_o),
  .alert_o(alert_o), .vendor_summary_bit_o(vendor_summary_bit_o),
  .int_ot_flag_o(int_ot_flag_o));

// ===== pmbus_host_model.sv
// host model: issues response byte writes and read selects
`timescale 1ns/1ps
module pmbus_host_model (
  input wire clk_sys_i, // clock
  output reg wr_stb_o = 1'b0, // one-cycle write strobe
  output reg [7:0] wr_cmd_o = 8'h00, // command code
  output reg [7:0] wr_data_o = 8'h00, // data byte
  output reg page_o = 1'b0, // page
  output reg [7:0] rd_cmd_o = 8'h00, // read select
  output reg rd_req_o = 1'b0 // read issued this cycle
);
  // strobe drops after one edge so back-to-back calls never collide
  task write(input [7:0] c, input [7:0] d, input p);
    @(posedge clk_sys_i); #1;
    {wr_stb_o, wr_cmd_o, wr_data_o, page_o} = {1'b1, c, d, p};
    @(posedge clk_sys_i); #1;
    wr_stb_o = 1'b0;
    wr_data_o = ~d; // stale data is not held after release
  endtask
  task read(input [7:0] c, input p);
    @(posedge clk_sys_i); #1;
    {rd_cmd_o, page_o, rd_req_o} = {c, p, 1'b1};
    @(posedge clk_sys_i); #1;
    rd_req_o = 1'b0;
  endtask
endmodule // pmbus_host_model

// ===== temperature_fault_response_tb.sv
// self-checking bench for the temperature fault block
`timescale 1ns/1ps
`include "temp_fault_map.vh"
module temperature_fault_response_tb;
  logic clk_sys_i = 0, srst_i = 1, clear_faults_i = 0, int_ot_i = 0, retry_tick_i = 0;
  logic [1:0] run_cmd_i = 0, ext_ot_i = 0, ext_ut_i = 0, alert_mask_i = 0;
  wire wr_stb_i, page_i, rd_req, cml_fault_o, alert_o, vendor_summary_bit_o, int_ot_flag_o;
  wire [7:0] wr_cmd_i, wr_data_i, rd_cmd_i, rd_data_o;
  wire [1:0] out_en_o, temp_summary_o, ext_ot_flag_o, ext_ut_flag_o;
  // packed view: alert, int flag, ut1, ot0, summaries, enables
  wire [7:0] st = {alert_o, int_ot_flag_o, ext_ut_flag_o[1], ext_ot_flag_o[0],
    temp_summary_o, out_en_o};
  // second view: vendor summary, ot1 and ut0, the flags the first view leaves out
  wire [7:0] st2 = {5'h00, vendor_summary_bit_o, ext_ot_flag_o[1], ext_ut_flag_o[0]};
  logic [7:0] cq[$], rq[$], d, v;
  logic ws, rs;
  int n_errors = 0, comparisons = 0, cycles = 0, i;
  always #25 clk_sys_i = ~clk_sys_i;
  temperature_fault_response temperature_fault_response_inst (.clk_sys_i(clk_sys_i),
    .srst_i(srst_i), .wr_stb_i(wr_stb_i), .wr_cmd_i(wr_cmd_i), .wr_data_i(wr_data_i),
    .page_i(page_i), .rd_cmd_i(rd_cmd_i), .rd_data_o(rd_data_o),
    .clear_faults_i(clear_faults_i), .run_cmd_i(run_cmd_i), .int_ot_i(int_ot_i),
    .ext_ot_i(ext_ot_i), .ext_ut_i(ext_ut_i), .retry_tick_i(retry_tick_i),
    .alert_mask_i(alert_mask_i), .out_en_o(out_en_o), .cml_fault_o(cml_fault_o),
    .alert_o(alert_o), .vendor_summary_bit_o(vendor_summary_bit_o),
    .int_ot_flag_o(int_ot_flag_o), .temp_summary_o(temp_summary_o),
    .ext_ot_flag_o(ext_ot_flag_o), .ext_ut_flag_o(ext_ut_flag_o));
  pmbus_host_model pmbus_host_model_inst (.clk_sys_i(clk_sys_i), .wr_stb_o(wr_stb_i),
    .wr_cmd_o(wr_cmd_i), .wr_data_o(wr_data_i), .page_o(page_i), .rd_cmd_o(rd_cmd_i),
    .rd_req_o(rd_req));
  //////////////////////////////////////////////////////////////////////
  task cmp(input [7:0] a, input [7:0] e);
    comparisons++;
    if (a !== e) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, a, e);
    end
  endtask
  task give_verdict;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task w(input [7:0] c, input [7:0] dd, input p, input e);
    cq.push_back({7'h00, e});
    pmbus_host_model_inst.write(c, dd, p);
  endtask
  task r(input [7:0] c, input p, input [7:0] e);
    rq.push_back(e);
    pmbus_host_model_inst.read(c, p);
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask
  // results land on the edge that samples the request; oldest note is compared
  always @(posedge clk_sys_i) begin
    ws = wr_stb_i;
    rs = rd_req;
    #2;
    if (ws) cmp({7'h00, cml_fault_o}, cq.pop_front());
    if (rs) cmp(rd_data_o, rq.pop_front());
  end
  // a hang counts as a mismatch
  always @(posedge clk_sys_i) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_errors++;
      give_verdict;
    end
  end
  initial begin
    d = $urandom(32'hdc0b_e20e);
    cyc(8);
    srst_i = 0;
    run_cmd_i = 2'b11;
    for (i = 0; i < 2; i++) begin
      r(`CMD_EXT_OT_ACTION, i[0], `RST_EXT_ACTION);
      r(`CMD_EXT_UT_ACTION, i[0], `RST_EXT_ACTION);
      r(`CMD_INT_OT_ACTION, i[0], `RST_INT_ACTION);
    end
    v = `RST_EXT_ACTION;
    // every response code, retry none, random ignored delay bits
    for (i = 0; i < 4; i++) begin
      d = {i[1:0], 3'b000, 3'($urandom)};
      w(`CMD_EXT_OT_ACTION, d, 1'b0, i[0]);
      if (!i[0]) v = d;
    end
    r(`CMD_EXT_OT_ACTION, 1'b0, v);
    for (i = 0; i < 4; i++) begin
      d = $urandom;
      w(`CMD_INT_OT_ACTION, d, 1'b0, !d[7] || d[5:3] != 3'b000);
    end
    r(`CMD_INT_OT_ACTION, 1'b0, `RST_INT_ACTION);
    w(`CMD_EXT_UT_ACTION, 8'h00, 1'b1, 1'b0);
    r(`CMD_EXT_UT_ACTION, 1'b0, `RST_EXT_ACTION);
    ext_ot_i = 2'b01;
    cyc(1);
    ext_ot_i = 0;
    cyc(4);
    cmp(st, 8'h96);
    retry_tick_i = 1;
    cyc(1);
    retry_tick_i = 0;
    cyc(3);
    cmp(st, 8'h96);
    clear_faults_i = 1;
    cyc(1);
    clear_faults_i = 0;
    cyc(3);
    cmp(st, 8'h03);
    alert_mask_i = 2'b10;
    ext_ut_i = 2'b10;
    cyc(1);
    ext_ut_i = 0;
    cyc(4);
    cmp(st, 8'h2b);
    run_cmd_i = 2'b01;
    cyc(2);
    run_cmd_i = 2'b11;
    alert_mask_i = 0;
    cyc(4);
    cmp(st, 8'h03);
    int_ot_i = 1;
    cyc(7);
    cmp(st, 8'hc0);
    cmp(st2, 8'h04);
    int_ot_i = 0;
    cyc(7);
    cmp(st, 8'hc3);
    clear_faults_i = 1;
    cyc(1);
    clear_faults_i = 0;
    ext_ot_i = 2'b10;
    cyc(1);
    ext_ot_i = 0;
    cyc(4);
    cmp(st, 8'h89);
    cmp(st2, 8'h02);
    retry_tick_i = 1;
    cyc(1);
    retry_tick_i = 0;
    cyc(3);
    cmp(st, 8'h8b);
    ext_ut_i = 2'b01;
    cyc(1);
    ext_ut_i = 0;
    cyc(4);
    cmp(st, 8'h8e);
    cmp(st2, 8'h03);
    give_verdict;
  end
endmodule // temperature_fault_response_tb
